// File: logic/cof_defines.svh
// Constants of the output framer: register indices, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the framer module and the bench.
`ifndef COF_DEFINES_SVH
`define COF_DEFINES_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define COF_REG_MODE1   8'h23
`define COF_REG_CSICFG  8'h6A
`define COF_REG_CTRL    8'h70
`define COF_REG_STAT    8'h71
`define COF_REG_TIMING  8'h72
`define COF_REG_RATE    8'h73
// ==========================================================
// Field positions and reset values
`define COF_M1_LSB      3
`define COF_LP_LSB      4
`define COF_CC_BIT      1
`define COF_DT_LSB      8
`define COF_MODE1_RST   32'h0000_0000
`define COF_CSICFG_RST  32'h0000_0000
`define COF_CTRL_RST    32'h0000_2400
// ==========================================================
// Packet data types
`define COF_DT_FS       6'h00
`define COF_DT_FE       6'h01
// ==========================================================
// Timing: clock rate, measuring window, blanking threshold
`define COF_CLK_MHZ     200
`define COF_WIN_NS      10000
`define COF_WIN_CYC     (`COF_WIN_NS * `COF_CLK_MHZ / 1000)
`define COF_HBLANK_PCLK 96
// ==========================================================
// Pixel clock limits in MHz and lane rate ratios
`define COF_1IN_MIN     25
`define COF_1IN_MAX     96
`define COF_2IN4_MIN    50
`define COF_2IN4_MAX    170
`define COF_2IN2_MIN    25
`define COF_2IN2_MAX    48
`define COF_RATIO_4L    7
`define COF_RATIO_2L    14
`endif

// File: logic/cof_pkg.sv
// Types shared by the output framer.
// Assumes nothing beyond the constants header.
package cof_pkg;
  // ==========================================================
  // Packet sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_FE, ST_GAP, ST_LINE, ST_CRC, ST_END} cof_st_t;
endpackage

// File: logic/cof_framer.sv
// Output framer: pixel stream to lane words, packets, lane states.
// Assumes a 200 MHz i_clk, pixel clock well below half of it, and an
// Avalon-MM master that holds each request until waitrequest is low.
`timescale 1ns/1ps
`include "cof_defines.svh"

// Overview of operation
// - one input, two lanes: 25-96 MHz, 14x.
// - two inputs, four lanes: 50-170 MHz, 7x.
// - two inputs, two lanes: 25-48 MHz, 14x.
// - merge both input streams into one packet stream.
// - replicate mirrors lanes and clock onto port one.
// - configuration from straps or overriding register bits.
// - lane/port code: 0-3 valid, 4-7 reserved.
// - single-port codes use port select; both ignore it.
// - pixel bits map directly onto payload bytes.
// - after sync ends send frame end, frame start.
// - each line valid rise sends one long packet.
// - data lanes stop after packet, clock keeps running.
// - half-rate clock is 3.5x or 7x pixel clock.
// - lane rate is 7x four lanes, 14x two.
// - clock leads data; first edge on first bit.
// - data in bursts, low power between bursts.
// - detect input format, derive output timing automatically.
// - measure rates from sync and line valid.
// - unused ports and lanes held in stop state.
// - override fields at 0x23[4:3] and 0x6A[5:4].
// - clock stops after 96 blank pixels, non-continuous.
module cof_framer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [2:0]  i_lane_port_strap,
  input  wire logic [2:0]  i_port_link_strap,
  input  wire logic        i_pix_clk,
  input  wire logic        i_vertical_sync,
  input  wire logic        i_line_valid_strobe,
  input  wire logic [23:0] i_pix_data0,
  input  wire logic [23:0] i_pix_data1,
  output logic      [31:0] o_port_zero_data,
  output logic      [3:0]  o_port_zero_data_hs,
  output logic             o_port_zero_clk_hs,
  output logic      [31:0] o_port_one_data_lanes,
  output logic      [3:0]  o_port_one_data_hs,
  output logic             o_port_one_clock_lane_hs,
  output logic             o_word_valid,
  output logic      [3:0]  o_lane_ratio,
  output logic             o_bc_rate_20,
  output logic             o_cable_coax
);
  // ==========================================================
  // Helper functions

  // Byte-lane merge for register writes.
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        o[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return o;
  endfunction

  // Pixel clock window check, figures in MHz; count is MHz times ten.
  function automatic logic in_rng(input logic [11:0] v, input int lo, input int hi);
    return (v >= 12'(lo * 10)) && (v <= 12'(hi * 10));
  endfunction

  // Reflected CRC-16 over three or six bytes of a pixel group.
  function automatic logic [15:0] crc_px(input logic [15:0] c, input logic [47:0] d,
                                         input logic dual);
    for (int i = 0; i < 6; i++) begin
      if (i < 3 || dual) begin
        for (int b = 0; b < 8; b++) begin
          c = ((c[0] ^ d[i*8+b]) != 1'b0) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
      end
    end
    return c;
  endfunction

  // Packet header: identifier, word count, position-syndrome check byte.
  function automatic logic [31:0] hdr(input logic [5:0] dt, input logic [15:0] wc);
    logic [23:0] d;
    logic [5:0]  e;
    d = {wc, 2'b00, dt};
    e = 6'h00;
    for (int i = 0; i < 24; i++) begin
      if (d[i]) begin
        e = e ^ 6'(i + 3);
      end
    end
    return {2'b00, e, d};
  endfunction

  // ==========================================================
  // Input synchronisers: straps, pixel clock, timing and pixel bits.
  // Stage one feeds only stage two; a bit counts once stages two and
  // three agree. Data are taken from stage three at the clock edge.
  localparam int SW = 57;
  logic [SW-1:0] s1_r, s2_r, s3_r, ag_r;
  always_ff @(posedge i_clk) begin
    s1_r <= {i_lane_port_strap, i_port_link_strap, i_pix_clk, i_vertical_sync,
             i_line_valid_strobe, i_pix_data1, i_pix_data0};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // Agreed level per bit; only the straps and the clock use it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ag_r <= '0;
    end else begin
      ag_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & ag_r);
    end
  end

  logic        pix_rise;  // One-cycle pulse per pixel clock rise.
  logic        vs_in;     // Sync level at the pixel edge.
  logic        de_in;     // Line valid level at the pixel edge.
  logic [47:0] px_in;     // Both pixel words, port one on top.
  assign pix_rise = s2_r[50] & s3_r[50] & ~ag_r[50];
  assign vs_in    = s3_r[49];
  assign de_in    = s3_r[48];
  assign px_in    = s3_r[47:0];

  // Sync and line valid as seen at the previous pixel edge.
  logic vs_px_r, de_px_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      vs_px_r <= 1'b0;
      de_px_r <= 1'b0;
    end else if (pix_rise) begin
      vs_px_r <= vs_in;
      de_px_r <= de_in;
    end
  end

  logic vs_fall, de_rise, de_fall;
  assign vs_fall = pix_rise & vs_px_r & ~vs_in;
  assign de_rise = pix_rise & ~de_px_r & de_in;
  assign de_fall = pix_rise & de_px_r & ~de_in;

  // ==========================================================
  // Registers reached over Avalon-MM.
  logic [31:0] mode1_r, csicfg_r, ctrl_r;   // Writable configuration.
  logic [31:0] stat_w, timing_w, rate_w;    // Read-only views.
  logic        rack_r;                      // Read answer stage.
  logic        hit;                         // Aligned access.
  logic [7:0]  idx;
  assign idx = i_avs_address[9:2];
  assign hit = (i_avs_address[1:0] == 2'b00);
  // Reads wait one cycle so read data come from a flop; writes never wait.
  assign o_avs_waitrequest = i_avs_read & ~rack_r;

  // Writes to the configuration registers; other offsets ignore writes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode1_r  <= `COF_MODE1_RST;
      csicfg_r <= `COF_CSICFG_RST;
      ctrl_r   <= `COF_CTRL_RST;
    end else if (i_avs_write && hit) begin
      case (idx)
        `COF_REG_MODE1:  mode1_r  <= be_merge(mode1_r, i_avs_writedata, i_avs_byteenable);
        `COF_REG_CSICFG: csicfg_r <= be_merge(csicfg_r, i_avs_writedata, i_avs_byteenable);
        `COF_REG_CTRL:   ctrl_r   <= be_merge(ctrl_r, i_avs_writedata, i_avs_byteenable);
        default: begin
        end
      endcase
    end
  end

  // Read answer; unmapped offsets read as zero.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rack_r         <= 1'b0;
      o_avs_readdata <= '0;
    end else begin
      rack_r <= i_avs_read & ~rack_r;
      if (i_avs_read && !rack_r) begin
        case (hit ? idx : 8'hFF)
          `COF_REG_MODE1:  o_avs_readdata <= mode1_r;
          `COF_REG_CSICFG: o_avs_readdata <= csicfg_r;
          `COF_REG_CTRL:   o_avs_readdata <= ctrl_r;
          `COF_REG_STAT:   o_avs_readdata <= stat_w;
          `COF_REG_TIMING: o_avs_readdata <= timing_w;
          `COF_REG_RATE:   o_avs_readdata <= rate_w;
          default:         o_avs_readdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Configuration decode.
  logic       ovr_lp, ovr_pl, repl, dual, cont;
  logic [5:0] dt;
  logic [2:0] lp_code, pl_code;
  logic       rsvd, lanes4, both, sel1, p0_on, p1_on;
  logic [3:0] lane_mask;
  assign ovr_lp = ctrl_r[0];
  assign ovr_pl = ctrl_r[1];
  assign repl   = ctrl_r[2];
  assign dual   = ctrl_r[3];
  assign dt     = ctrl_r[`COF_DT_LSB +: 6];
  assign cont   = csicfg_r[`COF_CC_BIT];
  // Register fields replace the lane/port code and the top two port link strap bits when enabled.
  assign lp_code = ovr_lp ? {1'b0, csicfg_r[`COF_LP_LSB +: 2]} : ag_r[56:54];
  assign pl_code = ovr_pl ? {mode1_r[`COF_M1_LSB +: 2], ag_r[51]} : ag_r[53:51];
  assign rsvd   = lp_code[2];
  assign lanes4 = ~lp_code[1];
  assign both   = lp_code[0];
  assign sel1   = pl_code[2];
  // Both-port codes ignore the port select.
  assign p0_on  = ~rsvd & (both | ~sel1);
  assign p1_on  = ~rsvd & (both | sel1 | repl);
  assign lane_mask = lanes4 ? 4'hF : 4'h3;
  assign o_bc_rate_20 = pl_code[1];
  assign o_cable_coax = pl_code[0];
  // Lane bit rate per pixel clock; the half-rate clock is half of it.
  assign o_lane_ratio = lanes4 ? 4'(`COF_RATIO_4L) : 4'(`COF_RATIO_2L);

  // ==========================================================
  // Pixel clock measurement: edges counted in a fixed window.
  logic [11:0] win_r, edg_r, pclk10_r;
  logic        rng_ok;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      win_r    <= '0;
      edg_r    <= '0;
      pclk10_r <= '0;
    end else if (win_r == 12'(`COF_WIN_CYC - 1)) begin
      win_r    <= '0;
      edg_r    <= 12'(pix_rise);
      pclk10_r <= edg_r;
    end else begin
      win_r <= win_r + 12'd1;
      edg_r <= edg_r + 12'(pix_rise);
    end
  end
  assign rng_ok = !dual ? in_rng(pclk10_r, `COF_1IN_MIN, `COF_1IN_MAX)
                : lanes4 ? in_rng(pclk10_r, `COF_2IN4_MIN, `COF_2IN4_MAX)
                : in_rng(pclk10_r, `COF_2IN2_MIN, `COF_2IN2_MAX);

  // ==========================================================
  // Format detection: pixels per line, lines and pixels per frame.
  logic [15:0] px_cnt_r, len_r, ln_cnt_r, lines_r, plen_r;
  logic [31:0] fr_cnt_r, frame_r;
  logic        lock_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      px_cnt_r <= '0;
      len_r    <= '0;
      ln_cnt_r <= '0;
      lines_r  <= '0;
      plen_r   <= '0;
      fr_cnt_r <= '0;
      frame_r  <= '0;
      lock_r   <= 1'b0;
    end else if (pix_rise) begin
      fr_cnt_r <= fr_cnt_r + 32'd1;
      if (de_in) begin
        px_cnt_r <= de_px_r ? px_cnt_r + 16'd1 : 16'd1;
      end
      if (de_rise) begin
        ln_cnt_r <= ln_cnt_r + 16'd1;
      end
      if (de_fall) begin
        len_r <= px_cnt_r;
      end
      if (vs_in && !vs_px_r) begin
        // A frame is locked when two frames in a row match.
        lines_r  <= ln_cnt_r;
        plen_r   <= len_r;
        frame_r  <= fr_cnt_r;
        lock_r   <= (ln_cnt_r == lines_r) && (len_r == plen_r) && (len_r != 16'd0);
        ln_cnt_r <= '0;
        fr_cnt_r <= 32'd1;
      end
    end
  end
  assign stat_w   = {12'h000, 4'(lanes4 ? `COF_RATIO_4L : `COF_RATIO_2L), 4'h0, lock_r,
                     o_cable_coax, o_bc_rate_20, lanes4, rng_ok, rsvd, pl_code, lp_code};
  assign timing_w = {lines_r, len_r};
  assign rate_w   = frame_r;

  // ==========================================================
  // Packet sequencer and byte queue.
  cof_pkg::cof_st_t st_r;
  logic [95:0] pend_r, push_d;
  logic [3:0]  pend_n_r, push_n, n_pop;
  logic [15:0] crc_r, wc;
  logic [47:0] px_bytes;
  logic        pop, drained;
  logic [1:0]  fill_r;
  assign pop      = (pend_n_r != 4'd0);
  assign n_pop    = pend_n_r - 4'(pop);
  assign drained  = (pend_n_r == 4'd0) && (fill_r == 2'd0);
  // Pixel bits go straight to bytes; two inputs give two pixels per edge.
  assign px_bytes = dual ? px_in : {24'h00_0000, px_in[23:0]};
  assign wc       = 16'(len_r * (dual ? 16'd6 : 16'd3));

  // Bytes pushed by each state.
  always_comb begin
    push_n = 4'd0;
    push_d = '0;
    case (st_r)
      cof_pkg::ST_IDLE: begin
        if (de_rise) begin
          push_n = dual ? 4'd10 : 4'd7;
          push_d = {16'h0000, px_bytes, hdr(dt, wc)};
        end else if (vs_fall) begin
          push_n = 4'd4;
          push_d = {64'h0, hdr(`COF_DT_FE, 16'h0000)};
        end
      end
      cof_pkg::ST_GAP: begin
        push_n = 4'd4;
        push_d = {64'h0, hdr(`COF_DT_FS, 16'h0000)};
      end
      cof_pkg::ST_LINE: begin
        if (pix_rise && de_in) begin
          push_n = dual ? 4'd6 : 4'd3;
          push_d = {48'h0, px_bytes};
        end
      end
      cof_pkg::ST_CRC: begin
        push_n = 4'd2;
        push_d = {80'h0, crc_r};
      end
      default: begin
      end
    endcase
  end

  // Queue: one byte leaves per cycle, new bytes join behind the rest.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_r   <= '0;
      pend_n_r <= '0;
    end else begin
      pend_r   <= (pop ? pend_r >> 8 : pend_r) | (push_d << {n_pop, 3'b000});
      pend_n_r <= n_pop + push_n;
    end
  end

  // Sequencer. A sync end seen during a line is not served.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= cof_pkg::ST_IDLE;
    end else begin
      case (st_r)
        cof_pkg::ST_IDLE: begin
          if (de_rise) begin
            st_r <= cof_pkg::ST_LINE;
          end else if (vs_fall) begin
            st_r <= cof_pkg::ST_FE;
          end
        end
        cof_pkg::ST_FE: begin
          if (drained) begin
            st_r <= cof_pkg::ST_GAP;
          end
        end
        cof_pkg::ST_GAP:  st_r <= cof_pkg::ST_END;
        cof_pkg::ST_LINE: begin
          if (de_fall) begin
            st_r <= cof_pkg::ST_CRC;
          end
        end
        cof_pkg::ST_CRC:  st_r <= cof_pkg::ST_END;
        cof_pkg::ST_END: begin
          if (drained) begin
            st_r <= cof_pkg::ST_IDLE;
          end
        end
        default: st_r <= cof_pkg::ST_IDLE;
      endcase
    end
  end

  // Payload checksum, restarted with the first pixel of each line.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      crc_r <= 16'hFFFF;
    end else if (st_r == cof_pkg::ST_IDLE && de_rise) begin
      crc_r <= crc_px(16'hFFFF, px_bytes, dual);
    end else if (st_r == cof_pkg::ST_LINE && pix_rise && de_in) begin
      crc_r <= crc_px(crc_r, px_bytes, dual);
    end
  end

  // ==========================================================
  // Lane assembler: bytes dealt across the active lanes.
  logic [31:0] word_r, data_r;
  logic        full, flush;
  assign full  = (fill_r == (lanes4 ? 2'd3 : 2'd1));
  assign flush = (st_r == cof_pkg::ST_FE || st_r == cof_pkg::ST_END) && !pop
                 && (fill_r != 2'd0);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      word_r       <= '0;
      data_r       <= '0;
      fill_r       <= '0;
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= 1'b0;
      if (pop && full) begin
        data_r       <= word_r | ({24'h00_0000, pend_r[7:0]} << {fill_r, 3'b000});
        o_word_valid <= 1'b1;
        word_r       <= '0;
        fill_r       <= '0;
      end else if (pop) begin
        word_r[{fill_r, 3'b000} +: 8] <= pend_r[7:0];
        fill_r <= fill_r + 2'd1;
      end else if (flush) begin
        // A short tail leaves zero-padded.
        data_r       <= word_r;
        o_word_valid <= 1'b1;
        word_r       <= '0;
        fill_r       <= '0;
      end
    end
  end
  assign o_port_zero_data      = data_r;
  assign o_port_one_data_lanes = data_r;

  // ==========================================================
  // Lane states. The clock lane follows the packet flag directly and
  // the data lanes one cycle later, so the clock is running before
  // the first payload bit.
  logic       act, act_r, clk_on;
  logic [6:0] blank_r;
  assign act    = (st_r != cof_pkg::ST_IDLE) && (st_r != cof_pkg::ST_GAP);
  // Non-continuous mode stops the clock only after a long blank.
  assign clk_on = cont || act || (blank_r < 7'(`COF_HBLANK_PCLK));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      blank_r <= 7'(`COF_HBLANK_PCLK);
    end else if (act) begin
      blank_r <= '0;
    end else if (pix_rise && blank_r < 7'(`COF_HBLANK_PCLK)) begin
      blank_r <= blank_r + 7'd1;
    end
  end

  // Unused ports and lanes stay in the stop state.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_r                    <= 1'b0;
      o_port_zero_data_hs      <= '0;
      o_port_one_data_hs       <= '0;
      o_port_zero_clk_hs       <= 1'b0;
      o_port_one_clock_lane_hs <= 1'b0;
    end else begin
      act_r                    <= act;
      o_port_zero_data_hs      <= {4{act_r & p0_on}} & lane_mask;
      o_port_one_data_hs       <= {4{act_r & p1_on}} & lane_mask;
      o_port_zero_clk_hs       <= clk_on & p0_on;
      o_port_one_clock_lane_hs <= clk_on & p1_on;
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_unused_lp;
    !lanes4 |=> (o_port_zero_data_hs[3:2] == 2'b00) || $past(lanes4);
  endproperty
  a_unused_lp: assert property (p_unused_lp) else $error("unused lane in HS");

  property p_rsvd;
    rsvd [*2] |=> (o_port_zero_data_hs == 4'h0) && (o_port_one_data_hs == 4'h0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code drives lanes");

  property p_port_sel;
    (!rsvd && !both && !repl && !sel1) [*2] |=> !o_port_one_clock_lane_hs;
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("port one active");

  property p_repl;
    (repl && p0_on) [*2] |=> (o_port_one_data_hs == o_port_zero_data_hs);
  endproperty
  a_repl: assert property (p_repl) else $error("replica lanes differ");

  property p_clk_lead;
    $rose(o_port_zero_data_hs[0]) |-> $past(o_port_zero_clk_hs);
  endproperty
  a_clk_lead: assert property (p_clk_lead) else $error("data before clock");

  property p_clk_after;
    $fell(act_r) && p0_on |-> ##1 o_port_zero_clk_hs;
  endproperty
  a_clk_after: assert property (p_clk_after) else $error("clock stopped at end");

  property p_clk_stop;
    $fell(clk_on) |-> !cont && (blank_r == 7'd96);
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock stopped early");

  property p_fe_fs;
    st_r == cof_pkg::ST_GAP |=> st_r == cof_pkg::ST_END ##0 pend_n_r == 4'd4;
  endproperty
  a_fe_fs: assert property (p_fe_fs) else $error("frame start missing");

  property p_line;
    (st_r == cof_pkg::ST_IDLE) && de_rise |=> (st_r == cof_pkg::ST_LINE) ##1 act_r;
  endproperty
  a_line: assert property (p_line) else $error("line packet not started");

  property p_ratio;
    o_lane_ratio == (lanes4 ? 4'd7 : 4'd14);
  endproperty
  a_ratio: assert property (p_ratio) else $error("lane ratio wrong");

  c_repl:  cover property (repl && o_port_one_data_hs != 4'h0);
  c_frame: cover property (st_r == cof_pkg::ST_GAP);
  c_dual:  cover property (dual && st_r == cof_pkg::ST_CRC);
endmodule  // cof_framer

// File: test/cof_rx_model.sv
// Receiver model: one record per burst on port zero, bursts on port one.
// Assumes lane 0 of a port is high speed during every burst.
`timescale 1ns/1ps
module cof_rx_model (
  input  wire logic        i_clk,
  input  wire logic        i_hs,
  input  wire logic        i_one_hs,
  input  wire logic        i_wv,
  input  wire logic [7:0]  i_lane0,
  output logic             o_done,
  output logic      [15:0] o_rec,
  output logic      [7:0]  o_one_n
);
  logic hs_r = 1'b0;  // Lane state one cycle ago, port zero.
  logic one_r = 1'b0; // Lane state one cycle ago, port one.
  initial begin
    o_done = 1'b0;
    o_rec = 16'h0000;
    o_one_n = 8'h00;
  end
  // ==========================================================
  // Capture: identifier is the first lane-0 byte, words are counted.
  // The record clears after the done pulse so no burst leaks into the next.
  always @(posedge i_clk) begin
    hs_r <= i_hs;
    one_r <= i_one_hs;
    o_done <= hs_r & ~i_hs;
    if (o_done) begin
      o_rec <= 16'h0000;
    end else if (i_wv) begin
      if (o_rec[7:0] == 8'h00) o_rec[15:8] <= i_lane0;
      o_rec[7:0] <= o_rec[7:0] + 8'h01;
    end
    if (i_one_hs & ~one_r) o_one_n <= o_one_n + 8'h01;
  end
endmodule // cof_rx_model

// File: test/tb_top.sv
// Bench for the output framer: registers, straps, packet stream.
// Assumes the framer and the receiver model are compiled first.
`timescale 1ns/1ps
`include "cof_defines.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h seen %h", n, e, s); end end
module tb_top;
  logic        i_clk = 1'b0, i_rst = 1'b1, pclk = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, vs = 1'b0, de = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, e, zd;
  logic [2:0]  lps = 3'h0, pls = 3'h0;
  logic [23:0] px0 = 24'h00_0000, px1 = 24'h00_0000;
  logic [3:0]  zhs, ohs, ratio;
  logic        wreq, zclk, wv, bc20, coax, done;
  logic [15:0] rec;
  logic [7:0]  one_n;
  logic [31:0] rq[$]; // Expected read data, oldest first.
  logic [15:0] bq[$]; // Expected burst records, oldest first.
  int          fail_count = 0, check_count = 0;
  // ==========================================================
  // Clocks: the link clock is unrelated in phase to the bench clock.
  initial forever #2.5 i_clk = ~i_clk;
  initial begin
    #7;
    forever #32 pclk = ~pclk;
  end
  cof_framer i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_lane_port_strap(lps),
    .i_port_link_strap(pls), .i_pix_clk(pclk), .i_vertical_sync(vs),
    .i_line_valid_strobe(de), .i_pix_data0(px0), .i_pix_data1(px1),
    .o_port_zero_data(zd), .o_port_zero_data_hs(zhs), .o_port_zero_clk_hs(zclk),
    .o_port_one_data_lanes(), .o_port_one_data_hs(ohs), .o_port_one_clock_lane_hs(),
    .o_word_valid(wv), .o_lane_ratio(ratio), .o_bc_rate_20(bc20), .o_cable_coax(coax));
  cof_rx_model i_rx (.i_clk(i_clk), .i_hs(zhs[0]), .i_one_hs(ohs[0]), .i_wv(wv),
    .i_lane0(zd[7:0]), .o_done(done), .o_rec(rec), .o_one_n(one_n));
  // ==========================================================
  // Result watcher: every answer is matched to the oldest note.
  always @(posedge i_clk) begin
    if (rd && wreq === 1'b0) begin
      e = rq.pop_front();
      `CHK("readdata", e, rdata)
    end
    if (done) begin
      e = {16'h0000, bq.pop_front()};
      `CHK("burst", e, {16'h0000, rec})
    end
  end
  // Pixels change after the link clock falls, far from its sampled rise.
  always @(negedge pclk) begin
    @(posedge i_clk);
    px0 <= 24'($urandom);
    px1 <= 24'($urandom);
  end
  // ==========================================================
  // Bus master: holds the request until waitrequest is seen low.
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    while (wreq !== 1'b0) @(posedge i_clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pw(input int n);
    repeat (n) @(negedge pclk);
    @(posedge i_clk);
  endtask
  // One frame of n lines of eight pixels, w lane words per line packet.
  // Blanking outlasts the clock-stop threshold.
  task automatic frame(input int n, input logic [7:0] w);
    bq.push_back({2'b00, `COF_DT_FE, 8'h01});
    bq.push_back({2'b00, `COF_DT_FS, 8'h01});
    pw(2);
    vs <= 1'b1;
    pw(3);
    vs <= 1'b0;
    repeat (n) begin
      pw(10);
      de <= 1'b1;
      bq.push_back({8'h24, w});
      pw(8);
      de <= 1'b0;
      pw(20);
      `CHK("clk_hs", 1'b1, zclk)
      `CHK("data_hs", 4'h0, zhs)
      pw(110);
      `CHK("clk_lp", 1'b0, zclk)
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(71298));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc(10'h1C0, `COF_CTRL_RST);
    rdc(10'h3FC, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      pls <= 3'(c);
      lps <= 3'(c);
      repeat (8) @(posedge i_clk);
      `CHK("bc20", c[1], bc20)
      `CHK("coax", c[0], coax)
      `CHK("ratio", c[1] ? 4'he : 4'h7, ratio)
    end
    pls <= 3'h0;
    lps <= 3'h0;
    bus(1'b1, 10'h1C0, 32'h0000_2403);
    bus(1'b1, 10'h08C, 32'h0000_0008);
    bus(1'b1, 10'h1A8, 32'h0000_0020);
    rdc(10'h08C, 32'h0000_0008);
    rdc(10'h1A8, 32'h0000_0020);
    repeat (4) @(posedge i_clk);
    `CHK("bc20_ovr", 1'b1, bc20)
    `CHK("ratio_ovr", 4'he, ratio)
    bus(1'b1, 10'h1C0, 32'h0000_2400);
    frame(2, 8'h08);
    `CHK("port_one", 8'h00, one_n)
    bus(1'b1, 10'h1C0, 32'h0000_2404);
    frame(2, 8'h08);
    `CHK("port_one", 8'h04, one_n)
    // Two inputs merged: six bytes per pixel edge, still replicated.
    bus(1'b1, 10'h1C0, 32'h0000_240C);
    frame(2, 8'h0E);
    `CHK("port_one", 8'h08, one_n)
    rdc(10'h1C8, 32'h0002_0008);
    rdc(10'h1C4, 32'h0007_0900);
    // Continuous clock mode keeps the clock lane running in blanking.
    bus(1'b1, 10'h1A8, 32'h0000_0002);
    repeat (2) @(posedge i_clk);
    `CHK("clk_cont", 1'b1, zclk)
    `CHK("left", 0, bq.size())
    stop_test;
  end
  // A hang counts as a mismatch; the tests need well under this span.
  initial begin
    repeat (40000) @(posedge i_clk);
    fail_count++;
    stop_test;
  end
endmodule // tb_top
